// ---- rtl/rfv_pkg.sv ----
// package of register map, field layout and timing for ring frequency validation
package rfv_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] RFV_IDX_CTRL3 = 8'h18;
    localparam logic [7:0] RFV_IDX_RSVD_A_LO = 8'h19;
    localparam logic [7:0] RFV_IDX_RSVD_A_HI = 8'h1c;
    localparam logic [7:0] RFV_IDX_VOLT = 8'h1d;
    localparam logic [7:0] RFV_IDX_RSVD_B_LO = 8'h1e;
    localparam logic [7:0] RFV_IDX_RSVD_B_HI = 8'h3b;
    localparam logic [7:0] RFV_IDX_ID = 8'h3c;
    localparam logic [7:0] RFV_IDX_STAT = 8'h40;
    localparam logic [7:0] RFV_IDX_MASK = 8'h41;
    localparam logic [7:0] RFV_IDX_WIN = 8'h42;

    // field positions
    localparam int RFV_EN_BIT = 7;
    localparam int RFV_FIELD_MSB = 5;
    localparam int RFV_VOLT_MSB = 6;
    localparam int RFV_ID_BIT = 2;
    localparam int RFV_ST_SLOW = 0;
    localparam int RFV_ST_FAST = 1;
    localparam int RFV_ST_PASS = 2;
    localparam int RFV_ST_W = 3;

    // reset values
    localparam logic [7:0] RFV_CTRL3_RST = 8'h19;
    localparam logic [5:0] RFV_WIN_RST = 6'h0a;
    localparam logic [RFV_ST_W-1:0] RFV_ST_RST = 3'h0;
    localparam logic [31:0] RFV_ZERO = 32'h0000_0000;

    // timing: countdown step
    localparam int RFV_CLK_HZ = 25_000_000;
    localparam int RFV_TICK_MS = 2;
    localparam int RFV_TICK_CYCLES = RFV_CLK_HZ / 1000 * RFV_TICK_MS;

    typedef struct packed {
        logic enable;
        logic [5:0] ras;
        logic [5:0] win;
    } rfv_ctrl_t;

    typedef struct packed {
        logic pass;
        logic too_fast;
        logic too_slow;
    } rfv_evt_t;

    typedef enum logic [0:0] {RFV_IDLE, RFV_ARMED} rfv_state_t;

    function automatic logic [7:0] rfv_index(input logic [9:0] adr);
        rfv_index = adr[9:2];
    endfunction : rfv_index

    function automatic logic rfv_in_range(input logic [7:0] idx, input logic [7:0] lo,
                                          input logic [7:0] hi);
        rfv_in_range = (idx >= lo) && (idx <= hi);
    endfunction : rfv_in_range

endpackage : rfv_pkg

// ---- rtl/rfv_tick_gen.sv ----
// divider producing one-cycle countdown ticks
`timescale 1ns/1ps
module rfv_tick_gen
    import rfv_pkg::*;
#(
    parameter int TICK_CYCLES = RFV_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic restart,
    output logic tick
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] div_q;
    logic [CW-1:0] div_d;

    // restart aligns tick phase to the event that loaded the timer
    always_comb begin
        if (restart || div_q == LAST) begin
            div_d = '0;
        end else begin
            div_d = div_q + ONE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    assign tick = !restart && (div_q == LAST);

endmodule : rfv_tick_gen

// ---- rtl/rfv_countdown.sv ----
// loadable countdown timer stepping on ticks
`timescale 1ns/1ps
module rfv_countdown #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic tick,
    output logic [W-1:0] count,
    output logic expired
);
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        if (load) begin
            cnt_d = load_val;
        end else if (tick && cnt_q != '0) begin
            cnt_d = cnt_q - ONE;
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    assign expired = (cnt_q == '0);

endmodule : rfv_countdown

// ---- rtl/rfv_ring_validation.sv ----
// ring frequency validation with wishbone register slave
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// (R1) validation runs only while the enable bit is set.
// (R2) the six-bit assertion-time field sets the lowest accepted ring frequency.
// (R3) each tip/ring event reloads the countdown with the assertion-time field, which then steps down.
// (R4) a second or later event after the countdown has expired invalidates the ring as too slow.
// (R5) assertion time minus maximum window, in 2 ms units, is the shortest allowed event gap.
// (R6) software sets assertion time from the lowest frequency and keeps the window no larger.
// (R7) reserved bits are written as zero by software and read back as zero here.
// (R8) the measured line voltage reads as a seven-bit value, one volt per step.
// (R9) bit two of the identity register returns the line-side identity code.
// (R10) the countdown steps once per 2 ms tick derived from the system clock.
module rfv_ring_validation
    import rfv_pkg::*;
#(
    parameter int TICK_CYCLES = RFV_TICK_CYCLES,
    parameter logic LINE_SIDE_ID = 1'b1 // arbitrary identity value
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tip_ring_event,
    input wire logic [6:0] line_voltage_level,
    output logic ring_valid,
    output logic ring_reject,
    output logic irq
);
    // bus side
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    rfv_ctrl_t ctrl_q, ctrl_d;
    logic [RFV_ST_W-1:0] stat_q, stat_d;
    logic [RFV_ST_W-1:0] mask_q, mask_d;
    logic irq_q, irq_d;
    logic [6:0] volt_q;
    logic access, wr, rd;
    logic [7:0] idx;

    // qualification side
    rfv_state_t state_q, state_d;
    logic valid_q, valid_d;
    logic reject_q, reject_d;
    rfv_evt_t evt;
    logic load;
    logic tick;
    logic [5:0] count;
    logic expired;

    rfv_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .restart(load),
        .tick(tick)
    );

    rfv_countdown #(
        .W(6)
    ) u_count (
        .clk(clk),
        .reset_n(reset_n),
        .load(load),
        .load_val(ctrl_q.ras), // R3
        .tick(tick), // R10
        .count(count),
        .expired(expired)
    );

    // qualification state machine
    always_comb begin
        state_d = state_q;
        valid_d = valid_q;
        reject_d = 1'b0;
        evt = '0;
        load = 1'b0;
        if (!ctrl_q.enable) begin // R1
            state_d = RFV_IDLE;
            valid_d = 1'b0;
        end else begin
            case (state_q)
                RFV_IDLE: begin
                    if (tip_ring_event) begin
                        load = 1'b1; // R3
                        state_d = RFV_ARMED;
                    end
                end
                RFV_ARMED: begin
                    if (tip_ring_event) begin
                        load = 1'b1; // R3
                        if (expired) begin // R4
                            evt.too_slow = 1'b1;
                            reject_d = 1'b1;
                            valid_d = 1'b0;
                        end else if (count > ctrl_q.win) begin // R5
                            // elapsed gap ras-count is below ras-win
                            evt.too_fast = 1'b1;
                            reject_d = 1'b1;
                            valid_d = 1'b0;
                        end else begin // R2
                            evt.pass = 1'b1;
                            valid_d = 1'b1;
                        end
                    end else if (expired) begin
                        // ringing has stopped; stay armed so a late event is judged
                        valid_d = 1'b0;
                    end
                end
                default: begin
                    state_d = RFV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= RFV_IDLE;
            valid_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            state_q <= state_d;
            valid_q <= valid_d;
            reject_q <= reject_d;
        end
    end

    // wishbone slave: one wait state, answer registered
    assign idx = rfv_index(wb_adr_i);
    assign access = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = access && wb_we_i && wb_sel_i[0];
    assign rd = access && !wb_we_i;

    always_comb begin
        ack_d = access;
        dat_d = RFV_ZERO;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        stat_d = stat_q;
        if (wr) begin
            case (idx)
                RFV_IDX_CTRL3: begin
                    // reserved bit 6 is dropped
                    ctrl_d.enable = wb_dat_i[RFV_EN_BIT];
                    ctrl_d.ras = wb_dat_i[RFV_FIELD_MSB:0];
                end
                RFV_IDX_WIN: ctrl_d.win = wb_dat_i[RFV_FIELD_MSB:0];
                RFV_IDX_MASK: mask_d = wb_dat_i[RFV_ST_W-1:0];
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (idx)
                RFV_IDX_CTRL3: begin
                    dat_d[RFV_EN_BIT] = ctrl_q.enable;
                    dat_d[RFV_FIELD_MSB:0] = ctrl_q.ras;
                end
                RFV_IDX_VOLT: dat_d[RFV_VOLT_MSB:0] = volt_q; // R8
                RFV_IDX_ID: dat_d[RFV_ID_BIT] = LINE_SIDE_ID; // R9
                RFV_IDX_WIN: dat_d[RFV_FIELD_MSB:0] = ctrl_q.win;
                RFV_IDX_STAT: begin
                    dat_d[RFV_ST_W-1:0] = stat_q;
                    stat_d = RFV_ST_RST; // read clears
                end
                RFV_IDX_MASK: dat_d[RFV_ST_W-1:0] = mask_q;
                default: dat_d = RFV_ZERO; // R7
            endcase
        end
        // new events win over a clearing read in the same cycle
        stat_d = stat_d | evt;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
            dat_q <= RFV_ZERO;
            ctrl_q <= '{enable: RFV_CTRL3_RST[RFV_EN_BIT],
                        ras: RFV_CTRL3_RST[RFV_FIELD_MSB:0],
                        win: RFV_WIN_RST};
            stat_q <= RFV_ST_RST;
            mask_q <= RFV_ST_RST;
            irq_q <= 1'b0;
            volt_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            volt_q <= line_voltage_level; // R8
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign ring_valid = valid_q;
    assign ring_reject = reject_q;
    assign irq = irq_q;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    logic rd_volt_q, rd_id_q, rd_rsvd_q;
    logic rsvd_hit;
    assign rsvd_hit = rfv_in_range(idx, RFV_IDX_RSVD_A_LO, RFV_IDX_RSVD_A_HI)
        || rfv_in_range(idx, RFV_IDX_RSVD_B_LO, RFV_IDX_RSVD_B_HI);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_volt_q <= 1'b0;
            rd_id_q <= 1'b0;
            rd_rsvd_q <= 1'b0;
        end else begin
            rd_volt_q <= rd && idx == RFV_IDX_VOLT;
            rd_id_q <= rd && idx == RFV_IDX_ID;
            rd_rsvd_q <= rd && rsvd_hit;
        end
    end

    property p_disabled_quiet;
        !ctrl_q.enable && !ctrl_d.enable |=> !ring_valid && state_q == RFV_IDLE;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("ring valid while off"); // R1

    property p_load_ras;
        ctrl_q.enable && tip_ring_event |=> count == $past(ctrl_q.ras);
    endproperty
    a_load_ras: assert property (p_load_ras) else $error("timer not loaded"); // R3

    property p_step_on_tick;
        count != $past(count) |-> $past(tick) || $past(load);
    endproperty
    a_step_on_tick: assert property (p_step_on_tick) else $error("timer moved off tick"); // R10

    property p_decrement;
        tick && !load && count != '0 |=> count == $past(count) - 6'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("timer did not step down"); // R3

    property p_too_slow;
        ctrl_q.enable && state_q == RFV_ARMED && tip_ring_event && expired
            |=> ring_reject && stat_q[RFV_ST_SLOW] && !ring_valid;
    endproperty
    a_too_slow: assert property (p_too_slow) else $error("late event not rejected"); // R4

    property p_too_fast;
        ctrl_q.enable && state_q == RFV_ARMED && tip_ring_event && !expired
            && count > ctrl_q.win |=> ring_reject && stat_q[RFV_ST_FAST];
    endproperty
    a_too_fast: assert property (p_too_fast) else $error("short gap not rejected"); // R5

    property p_pass;
        ctrl_q.enable && state_q == RFV_ARMED && tip_ring_event && !expired
            && count <= ctrl_q.win |=> ring_valid && !ring_reject;
    endproperty
    a_pass: assert property (p_pass) else $error("good event not accepted"); // R2

    property p_rsvd_zero;
        wb_ack_o && rd_rsvd_q |-> wb_dat_o == RFV_ZERO;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero"); // R7

    property p_volt_read;
        wb_ack_o && rd_volt_q |-> wb_dat_o[RFV_VOLT_MSB:0] == $past(volt_q)
            && wb_dat_o[31:RFV_VOLT_MSB+1] == '0;
    endproperty
    a_volt_read: assert property (p_volt_read) else $error("line voltage mismatch"); // R8

    property p_id_read;
        wb_ack_o && rd_id_q |-> wb_dat_o[RFV_ID_BIT] == LINE_SIDE_ID;
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity bit mismatch"); // R9

    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than a cycle");

    property p_off_no_reject;
        !ctrl_q.enable |=> !ring_reject;
    endproperty
    a_off_no_reject: assert property (p_off_no_reject) else $error("reject while off"); // R1

    property p_first_quiet;
        ctrl_q.enable && state_q == RFV_IDLE && tip_ring_event
            |=> !ring_reject && state_q == RFV_ARMED;
    endproperty
    a_first_quiet: assert property (p_first_quiet) else $error("first event judged"); // R3

    property p_expiry_drop;
        ctrl_q.enable && state_q == RFV_ARMED && expired && !tip_ring_event
            |=> !ring_valid;
    endproperty
    a_expiry_drop: assert property (p_expiry_drop) else $error("valid kept after expiry");

    // an event landing on a clearing read must survive it
    property p_set_wins;
        rd && idx == RFV_IDX_STAT && evt != '0 |=> stat_q == $past(evt);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to status read");

    property p_read_clear;
        rd && idx == RFV_IDX_STAT && evt == '0 |=> stat_q == RFV_ST_RST;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared");

    property p_irq_level;
        irq == |(stat_q & mask_q);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    property p_ctrl_write;
        wr && idx == RFV_IDX_CTRL3 |=> ctrl_q.enable == $past(wb_dat_i[RFV_EN_BIT])
            && ctrl_q.ras == $past(wb_dat_i[RFV_FIELD_MSB:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_win_write;
        wr && idx == RFV_IDX_WIN |=> ctrl_q.win == $past(wb_dat_i[RFV_FIELD_MSB:0]);
    endproperty
    a_win_write: assert property (p_win_write) else $error("window write lost");

    property p_mask_write;
        wr && idx == RFV_IDX_MASK |=> mask_q == $past(wb_dat_i[RFV_ST_W-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_rsvd_wr;
        wr && rsvd_hit |=> ctrl_q == $past(ctrl_q) && mask_q == $past(mask_q);
    endproperty
    a_rsvd_wr: assert property (p_rsvd_wr) else $error("reserved write landed"); // R7

    c_pass: cover property (ring_valid && !$past(ring_valid));
    c_slow: cover property (ring_reject && stat_q[RFV_ST_SLOW]);
    c_fast: cover property (ring_reject && stat_q[RFV_ST_FAST]);
    c_irq: cover property (irq && wb_ack_o);
    c_read_clear: cover property (rd && idx == RFV_IDX_STAT && stat_q != RFV_ST_RST);

endmodule : rfv_ring_validation

// ---- test/rfv_ring_source.sv ----
// model of the ring signal on the line, giving tip/ring threshold pulses
`timescale 1ns/1ps
module rfv_ring_source (
    input wire logic clk,
    output logic tip_ring_event
);
    initial tip_ring_event = 1'b0;

    // gap counts idle cycles since the previous pulse ended; keep it at least 1
    task automatic fire(input int gap);
        repeat (gap) @(posedge clk);
        tip_ring_event <= 1'b1;
        @(posedge clk);
        tip_ring_event <= 1'b0;
    endtask : fire
endmodule : rfv_ring_source

// ---- test/test_rfv_ring_validation.sv ----
// self-checking bench for ring frequency validation
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_rfv_ring_validation;
    import rfv_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack, tre, ring_valid, ring_reject, irq;
    logic [6:0] lvl = 7'h00;
    int errors = 0, compares = 0, cycles = 0;
    logic [7:0] rsv[5] = '{8'h19, 8'h1c, 8'h1e, 8'h3b, 8'h50};
    logic [6:0] lv[3] = '{7'h00, 7'h55, 7'h7f};
    localparam logic ID_EXP = 1'b1; // arbitrary identity value

    rfv_ring_validation #(.TICK_CYCLES(4), .LINE_SIDE_ID(ID_EXP)) rfv_ring_validation_i (
        .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tip_ring_event(tre), .line_voltage_level(lvl), .ring_valid(ring_valid),
        .ring_reject(ring_reject), .irq(irq)
    );
    rfv_ring_source rfv_ring_source_i (.clk(clk), .tip_ring_event(tre));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // request stands until ack is sampled high at a rising edge; data taken at that edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        wdat <= {24'h00_0000, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        if (ack !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: no bus answer", $time);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHECK(q, exp)
    endtask : rd_chk

    task automatic ev_chk(input int gap, input logic v, input logic r);
        rfv_ring_source_i.fire(gap);
        @(negedge clk);
        `CHECK(ring_valid, v)
        `CHECK(ring_reject, r)
    endtask : ev_chk

    // disabling first forces idle, so each sequence starts from a fresh reference
    task automatic arm(input logic [7:0] mask);
        wr(RFV_IDX_CTRL3, 8'h06);
        wr(RFV_IDX_WIN, 8'h02);
        wr(RFV_IDX_MASK, mask);
        wr(RFV_IDX_CTRL3, 8'h86);
    endtask : arm

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(RFV_IDX_CTRL3, 32'h0000_0019);
        rd_chk(RFV_IDX_WIN, 32'h0000_000a);
        rd_chk(RFV_IDX_STAT, 32'h0000_0000);
        rd_chk(RFV_IDX_MASK, 32'h0000_0000);
        rd_chk(RFV_IDX_ID, {29'h0000_0000, ID_EXP, 2'h0});
        foreach (rsv[i]) rd_chk(rsv[i], 32'h0000_0000);
        wr(8'h1c, 8'hff);
        rd_chk(8'h1c, 32'h0000_0000);
        wr(RFV_IDX_CTRL3, 8'h7f);
        rd_chk(RFV_IDX_CTRL3, 32'h0000_003f);
        $display("test registers done");
        foreach (lv[i]) begin
            lvl <= lv[i];
            rd_chk(RFV_IDX_VOLT, {25'h0, lv[i]});
        end
        $display("test line voltage done");
        wr(RFV_IDX_CTRL3, 8'h06);
        ev_chk(2, 1'b0, 1'b0);
        ev_chk(17, 1'b0, 1'b0);
        rd_chk(RFV_IDX_STAT, 32'h0000_0000);
        $display("test disabled done");
        arm(8'h07);
        ev_chk(2, 1'b0, 1'b0);
        ev_chk(3, 1'b0, 1'b1);
        `CHECK(irq, 1'b1)
        rd_chk(RFV_IDX_STAT, 32'h0000_0002);
        @(negedge clk);
        `CHECK(irq, 1'b0)
        rd_chk(RFV_IDX_STAT, 32'h0000_0000);
        ev_chk(17, 1'b1, 1'b0);
        rd_chk(RFV_IDX_STAT, 32'h0000_0004);
        @(negedge clk);
        `CHECK(ring_valid, 1'b1)
        repeat (30) @(posedge clk);
        @(negedge clk);
        `CHECK(ring_valid, 1'b0)
        ev_chk(1, 1'b0, 1'b1);
        rd_chk(RFV_IDX_STAT, 32'h0000_0001);
        $display("test gap checks done");
        arm(8'h00);
        ev_chk(2, 1'b0, 1'b0);
        ev_chk(3, 1'b0, 1'b1);
        `CHECK(irq, 1'b0)
        rd_chk(RFV_IDX_STAT, 32'h0000_0002);
        $display("test masked irq done");
        summarize();
    end
endmodule : test_rfv_ring_validation
